// [rtl/dma_map.vh]
// constant map for the multiply and add tile: modes, widths, stage codes
`ifndef DMA_MAP_VH
`define DMA_MAP_VH

// operating modes, one per tile
`define DMA_MODE_SIMPLE     2'h0
`define DMA_MODE_MAC        2'h1
`define DMA_MODE_TWO_SUM    2'h2
`define DMA_MODE_FOUR_SUM   2'h3

// operand width selections
`define DMA_WIDTH_9         2'h0
`define DMA_WIDTH_18        2'h1
`define DMA_WIDTH_36        2'h2

// register stage counts for control pipelines
`define DMA_STAGES_NONE     2'h0
`define DMA_STAGES_ONE      2'h1
`define DMA_STAGES_TWO      2'h2

// documented datapath widths
`define DMA_BUS_W           18
`define DMA_HALF_W          9
`define DMA_PROD_W          36
`define DMA_ACC_W           52
`define DMA_GUARD_W         16
`define DMA_SUM_W           54
`define DMA_WIDE_W          72

// clear and enable group assignment
`define DMA_GRP_INPUT       0
`define DMA_GRP_PIPE        1
`define DMA_GRP_OUTPUT      2
`define DMA_GRP_CTRL        3

`endif

// [rtl/dma_ctrl_delay.v]
// selectable zero, one or two stage delay line for control signals
`timescale 1ns/10ps
`include "dma_map.vh"

module dma_ctrl_delay #(
  parameter W = 2
) (
  input  wire         core_clk,
  input  wire         rst,
  input  wire         clear,
  input  wire         enable,
  input  wire [1:0]   stages,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);

  reg [W-1:0] first_reg;
  reg [W-1:0] second_reg;

  // both stages hold while the enable group is low
  always @(posedge core_clk) begin
    if (rst || clear) begin
      first_reg  <= {W{1'b0}};
      second_reg <= {W{1'b0}};
    end else if (enable) begin
      first_reg  <= d;
      second_reg <= first_reg;
    end
  end

  // tap chosen statically so latency matches the data pipeline
  assign q = (stages == `DMA_STAGES_NONE) ? d :
             (stages == `DMA_STAGES_ONE)  ? first_reg : second_reg;

endmodule

// [rtl/dma_mult_unit.v]
// one 18x18 multiplier sub-block, splittable into two 9x9 multipliers
`timescale 1ns/10ps
`include "dma_map.vh"

module dma_mult_unit (
  input  wire        sign_a,
  input  wire        sign_b,
  input  wire        narrow,
  input  wire [17:0] op_a,
  input  wire [17:0] op_b,
  output wire [35:0] prod
);

  // one extra bit carries the sign choice; full precision either way
  wire signed [18:0] wide_a = {sign_a & op_a[17], op_a};
  wire signed [18:0] wide_b = {sign_b & op_b[17], op_b};
  wire signed [37:0] wide_p = wide_a * wide_b;

  wire signed [9:0]  lo_a = {sign_a & op_a[8], op_a[8:0]};
  wire signed [9:0]  lo_b = {sign_b & op_b[8], op_b[8:0]};
  wire signed [9:0]  hi_a = {sign_a & op_a[17], op_a[17:9]};
  wire signed [9:0]  hi_b = {sign_b & op_b[17], op_b[17:9]};
  wire signed [19:0] lo_p = lo_a * lo_b;
  wire signed [19:0] hi_p = hi_a * hi_b;

  // narrow packs two 18-bit products: low half in bits 17:0
  assign prod = narrow ? {hi_p[17:0], lo_p[17:0]} : wide_p[35:0];

endmodule

// [rtl/dma_tile.v]
// multiply and add tile: input chains, four multipliers, adders, outputs
`timescale 1ns/10ps
`include "dma_map.vh"

module dma_tile (
  input  wire         core_clk,
  input  wire         rst,
  input  wire [1:0]   mode_select,
  input  wire [1:0]   width_select,
  input  wire         mult_ctrl_stages,
  input  wire [1:0]   adder_ctrl_stages,
  input  wire         extra_output_stage,
  input  wire         product_reg_enable,
  input  wire         shift_data_enable,
  input  wire         shift_coef_enable,
  input  wire [3:0]   group_clear,
  input  wire [3:0]   group_enable,
  input  wire         operand_a_signed,
  input  wire         operand_b_signed,
  input  wire         upper_add_sub_select,
  input  wire         lower_add_sub_select,
  input  wire         accumulator_load_first,
  input  wire         accumulator_load_second,
  input  wire [17:0]  operand_a_bus_first,
  input  wire [17:0]  operand_b_bus_first,
  input  wire [17:0]  operand_a_bus_second,
  input  wire [17:0]  operand_b_bus_second,
  input  wire [17:0]  operand_a_bus_third,
  input  wire [17:0]  operand_b_bus_third,
  input  wire [17:0]  operand_a_bus_fourth,
  input  wire [17:0]  operand_b_bus_fourth,
  input  wire [17:0]  shift_data_in,
  input  wire [17:0]  shift_coef_in,
  output wire [17:0]  shift_data_out,
  output wire [17:0]  shift_coef_out,
  output wire [17:0]  result_bus_first,
  output wire [17:0]  result_bus_second,
  output wire [17:0]  result_bus_third,
  output wire [17:0]  result_bus_fourth,
  output wire [17:0]  result_bus_fifth,
  output wire [17:0]  result_bus_sixth,
  output wire [17:0]  result_bus_seventh,
  output wire [17:0]  result_bus_last,
  output reg          overflow_first,
  output reg          overflow_second
);

  localparam BW = `DMA_BUS_W;
  localparam PW = `DMA_PROD_W;
  localparam AW = `DMA_ACC_W;
  localparam SW = `DMA_SUM_W;
  localparam XW = `DMA_WIDE_W;

  // static decode of mode and width; one mode at a time per tile
  wire mode_simple = (mode_select == `DMA_MODE_SIMPLE);
  wire mode_mac    = (mode_select == `DMA_MODE_MAC);
  wire mode_two    = (mode_select == `DMA_MODE_TWO_SUM);
  wire mode_four   = (mode_select == `DMA_MODE_FOUR_SUM);
  // 36-bit width only exists in simple mode; elsewhere it acts as 18
  wire w36 = mode_simple && (width_select == `DMA_WIDTH_36);
  wire w9  = (width_select == `DMA_WIDTH_9);

  wire clr_in   = group_clear[`DMA_GRP_INPUT];
  wire clr_pipe = group_clear[`DMA_GRP_PIPE];
  wire clr_out  = group_clear[`DMA_GRP_OUTPUT];
  wire clr_ctrl = group_clear[`DMA_GRP_CTRL];
  wire ena_in   = group_enable[`DMA_GRP_INPUT];
  wire ena_pipe = group_enable[`DMA_GRP_PIPE];
  wire ena_out  = group_enable[`DMA_GRP_OUTPUT];
  wire ena_ctrl = group_enable[`DMA_GRP_CTRL];

  // sign-extend a 36-bit product to the 54-bit sum width
  function [SW-1:0] ext_prod;
    input [PW-1:0] p;
    input          sig;
    begin
      ext_prod = {{(SW-PW){sig & p[PW-1]}}, p};
    end
  endfunction

  // sign-extend an 18-bit half product to 36 bits
  function [PW-1:0] ext_half;
    input [BW-1:0] p;
    input          sig;
    begin
      ext_half = {{(PW-BW){sig & p[BW-1]}}, p};
    end
  endfunction

  // multiplier side sign controls, none or one stage
  wire [1:0] mult_sign;
  dma_ctrl_delay #(.W(2)) u_mult_ctrl (
    .core_clk (core_clk),
    .rst      (rst),
    .clear    (clr_ctrl),
    .enable   (ena_ctrl),
    .stages   ({1'b0, mult_ctrl_stages}),
    .d        ({operand_b_signed, operand_a_signed}),
    .q        (mult_sign)
  );

  // adder side controls, none, one or two stages
  wire [5:0] add_ctrl;
  dma_ctrl_delay #(.W(6)) u_add_ctrl (
    .core_clk (core_clk),
    .rst      (rst),
    .clear    (clr_ctrl),
    .enable   (ena_ctrl),
    .stages   (adder_ctrl_stages),
    .d        ({accumulator_load_second, accumulator_load_first,
                lower_add_sub_select, upper_add_sub_select,
                operand_b_signed, operand_a_signed}),
    .q        (add_ctrl)
  );
  wire add_sa    = add_ctrl[0];
  wire add_sb    = add_ctrl[1];
  wire upper_add = add_ctrl[2];
  wire lower_add = add_ctrl[3];
  wire [1:0] acc_load = add_ctrl[5:4];

  // chains are refused at 36 bits: wide operands load only in parallel
  wire chain_data = shift_data_enable & ~w36;
  wire chain_coef = shift_coef_enable & ~w36;

  wire [4*BW-1:0] bus_a = {operand_a_bus_fourth, operand_a_bus_third,
                           operand_a_bus_second, operand_a_bus_first};
  wire [4*BW-1:0] bus_b = {operand_b_bus_fourth, operand_b_bus_third,
                           operand_b_bus_second, operand_b_bus_first};

  reg  [BW-1:0] a_reg [0:3];
  reg  [BW-1:0] b_reg [0:3];
  reg  [PW-1:0] prod_reg [0:3];
  wire [PW-1:0] prod_raw [0:3];
  wire [PW-1:0] prod [0:3];
  wire [3:0]    prod_sig;

  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_sub
      // chain source: tile input for the first unit, else the previous one
      wire [BW-1:0] a_chain = (i == 0) ? shift_data_in : a_reg[(i+3)%4];
      wire [BW-1:0] b_chain = (i == 0) ? shift_coef_in : b_reg[(i+3)%4];

      // input registers, parallel or shifted per chain
      always @(posedge core_clk) begin
        if (rst || clr_in) begin
          a_reg[i] <= {BW{1'b0}};
          b_reg[i] <= {BW{1'b0}};
        end else if (ena_in) begin
          a_reg[i] <= chain_data ? a_chain : bus_a[i*BW +: BW];
          b_reg[i] <= chain_coef ? b_chain : bus_b[i*BW +: BW];
        end
      end

      // wide mode: first buses are the upper halves, second the lower
      wire [BW-1:0] op_a = w36 ? ((i < 2) ? a_reg[0] : a_reg[1]) : a_reg[i];
      wire [BW-1:0] op_b = w36 ? ((i % 2 == 0) ? b_reg[0] : b_reg[1])
                               : b_reg[i];
      // lower halves of a wide operand are always unsigned magnitudes
      wire sa_m = mult_sign[0] & (~w36 | (i < 2));
      wire sb_m = mult_sign[1] & (~w36 | (i % 2 == 0));
      assign prod_sig[i] = (add_sa & (~w36 | (i < 2))) |
                           (add_sb & (~w36 | (i % 2 == 0)));

      dma_mult_unit u_mult (
        .sign_a (sa_m),
        .sign_b (sb_m),
        .narrow (w9),
        .op_a   (op_a),
        .op_b   (op_b),
        .prod   (prod_raw[i])
      );

      // optional product register; in wide mode a multiplier pipe stage
      always @(posedge core_clk) begin
        if (rst || clr_pipe)
          prod_reg[i] <= {PW{1'b0}};
        else if (ena_pipe)
          prod_reg[i] <= prod_raw[i];
      end
      assign prod[i] = product_reg_enable ? prod_reg[i] : prod_raw[i];
    end
  endgenerate

  // shift chains continue into the next tile of the column
  assign shift_data_out = a_reg[3];
  assign shift_coef_out = b_reg[3];

  // wide product: hi*hi<<36 + cross terms<<18 + lo*lo
  wire [XW-1:0] w_hh = {{(XW-PW){prod_sig[0] & prod[0][PW-1]}}, prod[0]};
  wire [XW-1:0] w_hl = {{(XW-PW){prod_sig[1] & prod[1][PW-1]}}, prod[1]};
  wire [XW-1:0] w_lh = {{(XW-PW){prod_sig[2] & prod[2][PW-1]}}, prod[2]};
  wire [XW-1:0] w_ll = {{(XW-PW){1'b0}}, prod[3]};
  wire [XW-1:0] wide_prod = {w_hh[PW-1:0], {PW{1'b0}}} +
                            {w_hl[XW-BW-1:0], {BW{1'b0}}} +
                            {w_lh[XW-BW-1:0], {BW{1'b0}}} + w_ll;

  // first-stage adders, 18-bit width: upper pair and lower pair
  wire [SW-1:0] e0 = ext_prod(prod[0], prod_sig[0]);
  wire [SW-1:0] e1 = ext_prod(prod[1], prod_sig[1]);
  wire [SW-1:0] e2 = ext_prod(prod[2], prod_sig[2]);
  wire [SW-1:0] e3 = ext_prod(prod[3], prod_sig[3]);
  // upper low-subtract gives the real part, lower add the imaginary
  wire [SW-1:0] sum_up = upper_add ? e0 + e1 : e0 - e1;
  wire [SW-1:0] sum_lo = lower_add ? e2 + e3 : e2 - e3;

  // first-stage adders, 9-bit width: four independent pairs
  wire [PW-1:0] h0l = ext_half(prod[0][BW-1:0], prod_sig[0]);
  wire [PW-1:0] h0h = ext_half(prod[0][PW-1:BW], prod_sig[0]);
  wire [PW-1:0] h1l = ext_half(prod[1][BW-1:0], prod_sig[1]);
  wire [PW-1:0] h1h = ext_half(prod[1][PW-1:BW], prod_sig[1]);
  wire [PW-1:0] h2l = ext_half(prod[2][BW-1:0], prod_sig[2]);
  wire [PW-1:0] h2h = ext_half(prod[2][PW-1:BW], prod_sig[2]);
  wire [PW-1:0] h3l = ext_half(prod[3][BW-1:0], prod_sig[3]);
  wire [PW-1:0] h3h = ext_half(prod[3][PW-1:BW], prod_sig[3]);
  wire [PW-1:0] q0 = upper_add ? h0l + h1l : h0l - h1l;
  wire [PW-1:0] q1 = upper_add ? h0h + h1h : h0h - h1h;
  wire [PW-1:0] q2 = lower_add ? h2l + h3l : h2l - h3l;
  wire [PW-1:0] q3 = lower_add ? h2h + h3h : h2h - h3h;

  // second level: sum of the two first-stage results
  wire [SW-1:0] four_sum   = sum_up + sum_lo;
  wire [PW-1:0] four_sum_l = q0 + q2;
  wire [PW-1:0] four_sum_h = q1 + q3;

  // accumulators on the second and fourth multipliers only
  reg  [AW-1:0] acc_reg [0:1];
  wire [1:0]    ovf_next;
  genvar k;
  generate
    for (k = 0; k < 2; k = k + 1) begin : g_acc
      wire [PW-1:0] src = prod[2*k+1];
      wire          sig = prod_sig[2*k+1];
      wire          add = (k == 0) ? upper_add : lower_add;
      // 9-bit width accumulates the low product of the unit
      wire [PW-1:0] p36 = w9 ? ext_half(src[BW-1:0], sig) : src;
      wire [AW-1:0] p52 = {{(AW-PW){sig & p36[PW-1]}}, p36};
      // one extra bit catches carry out or borrow
      wire [AW:0] acc_x = {sig & acc_reg[k][AW-1], acc_reg[k]};
      wire [AW:0] p_x   = {sig & p52[AW-1], p52};
      wire [AW:0] total = add ? acc_x + p_x : acc_x - p_x;
      // signed: result sign disagrees with extension; unsigned: wrap
      assign ovf_next[k] = mode_mac & ~acc_load[k] &
                           (sig ? (total[AW] ^ total[AW-1]) : total[AW]);

      // accumulator always registered; load replaces, never adds
      always @(posedge core_clk) begin
        if (rst || clr_out || !mode_mac)
          acc_reg[k] <= {AW{1'b0}};
        else if (ena_out)
          acc_reg[k] <= acc_load[k] ? p52 : total[AW-1:0];
      end
    end
  endgenerate

  wire [SW-1:0] acc0_ext = {{(SW-AW){prod_sig[1] & acc_reg[0][AW-1]}},
                            acc_reg[0]};
  wire [SW-1:0] acc1_ext = {{(SW-AW){prod_sig[3] & acc_reg[1][AW-1]}},
                            acc_reg[1]};

  // output select by mode; unused buses read as zero
  reg [8*BW-1:0] result_next;
  always @* begin
    case (mode_select)
      `DMA_MODE_SIMPLE: begin
        if (w36)
          result_next = {{(8*BW-XW){1'b0}}, wide_prod};
        else
          result_next = {prod[3], prod[2], prod[1], prod[0]};
      end
      `DMA_MODE_MAC: begin
        // accumulator value lags the product by its own register
        result_next = {{BW{1'b0}}, acc1_ext, {BW{1'b0}}, acc0_ext};
      end
      `DMA_MODE_TWO_SUM: begin
        if (w9)
          result_next = {q3, q2, q1, q0};
        else
          result_next = {{BW{1'b0}}, sum_lo, {BW{1'b0}}, sum_up};
      end
      `DMA_MODE_FOUR_SUM: begin
        if (w9)
          result_next = {{PW{1'b0}}, four_sum_h, {PW{1'b0}}, four_sum_l};
        else
          result_next = {{(8*BW-SW){1'b0}}, four_sum};
      end
      default: result_next = {(8*BW){1'b0}};
    endcase
  end

  // accumulator output is already a register, yet it still passes through the first output stage
  wire [8*BW-1:0] stage_in = mode_mac ? {(8*BW){1'b0}} : result_next;
  reg  [8*BW-1:0] out_reg;
  reg  [8*BW-1:0] out2_reg;
  always @(posedge core_clk) begin
    if (rst || clr_out) begin
      out_reg  <= {(8*BW){1'b0}};
      out2_reg <= {(8*BW){1'b0}};
    end else if (ena_out) begin
      out_reg  <= mode_mac ? result_next : stage_in;
      out2_reg <= out_reg;
    end
  end
  wire [8*BW-1:0] out_sel = extra_output_stage ? out2_reg : out_reg;

  assign result_bus_first   = out_sel[0*BW +: BW];
  assign result_bus_second  = out_sel[1*BW +: BW];
  assign result_bus_third   = out_sel[2*BW +: BW];
  assign result_bus_fourth  = out_sel[3*BW +: BW];
  assign result_bus_fifth   = out_sel[4*BW +: BW];
  assign result_bus_sixth   = out_sel[5*BW +: BW];
  assign result_bus_seventh = out_sel[6*BW +: BW];
  assign result_bus_last    = out_sel[7*BW +: BW];

  // overflow is a registered level per update, not sticky
  always @(posedge core_clk) begin
    if (rst || clr_out || !mode_mac) begin
      overflow_first  <= 1'b0;
      overflow_second <= 1'b0;
    end else if (ena_out) begin
      overflow_first  <= ovf_next[0];
      overflow_second <= ovf_next[1];
    end
  end

endmodule

// [testbench/dma_ovf_latch.sv]
// user-side sticky latch kept on the tile's registered overflow flag
`timescale 1ns/10ps
module dma_ovf_latch (
  input  wire core_clk,
  input  wire clear,
  input  wire flag,
  output reg  sticky
);
  // the tile only reports the current update, so holding it is our job
  always @(posedge core_clk) begin
    if (clear)
      sticky <= 1'b0;
    else if (flag)
      sticky <= 1'b1;
  end
endmodule

// [testbench/dma_tile_assertions.sv]
// port-level timing and mode checks for the multiply and add tile
`timescale 1ns/10ps
`include "dma_map.vh"
module dma_tile_checker (
  input wire        core_clk,
  input wire        rst,
  input wire [1:0]  mode_select,
  input wire [1:0]  width_select,
  input wire        extra_output_stage,
  input wire        product_reg_enable,
  input wire        shift_data_enable,
  input wire        shift_coef_enable,
  input wire [3:0]  group_clear,
  input wire [3:0]  group_enable,
  input wire [17:0] operand_a_bus_first,
  input wire [17:0] operand_b_bus_first,
  input wire [17:0] operand_a_bus_fourth,
  input wire [17:0] shift_data_in,
  input wire [17:0] shift_data_out,
  input wire [17:0] result_bus_first,
  input wire [17:0] result_bus_fourth,
  input wire [17:0] result_bus_last,
  input wire        overflow_first,
  input wire        overflow_second
);
  default clocking cb @(posedge core_clk); endclocking
  // plain 18x18 run: low product bits do not depend on signedness
  sequence s_simple;
    !rst && mode_select == `DMA_MODE_SIMPLE && width_select == `DMA_WIDTH_18
    && product_reg_enable && !extra_output_stage && !shift_data_enable
    && !shift_coef_enable && group_enable == 4'hf && group_clear == 4'h0;
  endsequence
  property p_reset_zero;
    rst |=> result_bus_first == 18'h0 && result_bus_last == 18'h0
      && !overflow_first && !overflow_second;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("outputs not cleared by reset");
  property p_ovf_mac_only;
    disable iff (rst)
    mode_select != `DMA_MODE_MAC && $past(mode_select) != `DMA_MODE_MAC
      |-> !overflow_first && !overflow_second;
  endproperty
  a_ovf_mac_only: assert property (p_ovf_mac_only)
    else $error("overflow raised outside accumulate mode");
  property p_simple_latency;
    disable iff (rst)
    s_simple [*3] |=> result_bus_first ==
      $past(operand_a_bus_first, 3) * $past(operand_b_bus_first, 3);
  endproperty
  a_simple_latency: assert property (p_simple_latency)
    else $error("simple product wrong or late");
  property p_chain_shift;
    disable iff (rst)
    (shift_data_enable && width_select != `DMA_WIDTH_36 && group_enable[0]
     && !group_clear[0]) [*4] |=> shift_data_out == $past(shift_data_in, 4);
  endproperty
  a_chain_shift: assert property (p_chain_shift)
    else $error("data chain does not shift through four stages");
  property p_parallel_load;
    disable iff (rst)
    (!shift_data_enable || (mode_select == `DMA_MODE_SIMPLE
      && width_select == `DMA_WIDTH_36)) && group_enable[0]
      && !group_clear[0] |=> shift_data_out == $past(operand_a_bus_fourth);
  endproperty
  a_parallel_load: assert property (p_parallel_load)
    else $error("chain used where only parallel load is allowed");
  property p_group_hold;
    disable iff (rst)
    group_enable == 4'h0 && group_clear == 4'h0 |=> $stable(result_bus_first)
      && $stable(shift_data_out) && $stable(overflow_first);
  endproperty
  a_group_hold: assert property (p_group_hold)
    else $error("registers moved with enables low");
  property p_out_clear;
    disable iff (rst)
    group_clear[2] && group_enable[2]
      |=> result_bus_first == 18'h0 && !overflow_first;
  endproperty
  a_out_clear: assert property (p_out_clear)
    else $error("output clear ignored");
  property p_mac_unused;
    disable iff (rst)
    mode_select == `DMA_MODE_MAC && $past(mode_select) == `DMA_MODE_MAC
      |-> result_bus_fourth == 18'h0 && result_bus_last == 18'h0;
  endproperty
  a_mac_unused: assert property (p_mac_unused)
    else $error("unused bus driven in accumulate mode");
endmodule
bind dma_tile dma_tile_checker u_chk (
  .core_clk(core_clk), .rst(rst), .mode_select(mode_select),
  .width_select(width_select), .extra_output_stage(extra_output_stage),
  .product_reg_enable(product_reg_enable),
  .shift_data_enable(shift_data_enable),
  .shift_coef_enable(shift_coef_enable),
  .group_clear(group_clear), .group_enable(group_enable),
  .operand_a_bus_first(operand_a_bus_first),
  .operand_b_bus_first(operand_b_bus_first),
  .operand_a_bus_fourth(operand_a_bus_fourth),
  .shift_data_in(shift_data_in), .shift_data_out(shift_data_out),
  .result_bus_first(result_bus_first), .result_bus_fourth(result_bus_fourth),
  .result_bus_last(result_bus_last), .overflow_first(overflow_first),
  .overflow_second(overflow_second));

// [testbench/dma_tile_test.sv]
// self-checking bench for the multiply and add tile
`timescale 1ns/10ps
`include "dma_map.vh"
module dma_tile_test;
  reg         core_clk;
  reg         rst;
  reg  [1:0]  mode_select;
  reg  [1:0]  width_select;
  reg         mult_ctrl_stages;
  reg  [1:0]  adder_ctrl_stages;
  reg         extra_output_stage;
  reg         product_reg_enable;
  reg         shift_data_enable;
  reg         shift_coef_enable;
  reg  [3:0]  group_clear;
  reg  [3:0]  group_enable;
  reg         sign_a;
  reg         sign_b;
  reg         add_upper;
  reg         add_lower;
  reg         load_first;
  reg         load_second;
  reg  [17:0] op_a [0:3];
  reg  [17:0] op_b [0:3];
  reg  [17:0] shift_data_in;
  reg  [17:0] shift_coef_in;
  wire [17:0] shift_data_out;
  wire [17:0] shift_coef_out;
  wire [17:0] res [0:7];
  wire        overflow_first;
  wire        overflow_second;
  wire        ovf_sticky;
  wire [53:0] acc0 = {res[2], res[1], res[0]};
  wire [53:0] acc1 = {res[6], res[5], res[4]};
  reg  [71:0] e;
  reg  [53:0] prev;
  integer     mismatches;
  integer     check_count;
  integer     i;
  integer     j;
  dma_tile u_dut (
    .core_clk(core_clk), .rst(rst), .mode_select(mode_select),
    .width_select(width_select), .mult_ctrl_stages(mult_ctrl_stages),
    .adder_ctrl_stages(adder_ctrl_stages),
    .extra_output_stage(extra_output_stage),
    .product_reg_enable(product_reg_enable),
    .shift_data_enable(shift_data_enable),
    .shift_coef_enable(shift_coef_enable),
    .group_clear(group_clear), .group_enable(group_enable),
    .operand_a_signed(sign_a), .operand_b_signed(sign_b),
    .upper_add_sub_select(add_upper), .lower_add_sub_select(add_lower),
    .accumulator_load_first(load_first),
    .accumulator_load_second(load_second),
    .operand_a_bus_first(op_a[0]), .operand_b_bus_first(op_b[0]),
    .operand_a_bus_second(op_a[1]), .operand_b_bus_second(op_b[1]),
    .operand_a_bus_third(op_a[2]), .operand_b_bus_third(op_b[2]),
    .operand_a_bus_fourth(op_a[3]), .operand_b_bus_fourth(op_b[3]),
    .shift_data_in(shift_data_in), .shift_coef_in(shift_coef_in),
    .shift_data_out(shift_data_out), .shift_coef_out(shift_coef_out),
    .result_bus_first(res[0]), .result_bus_second(res[1]),
    .result_bus_third(res[2]), .result_bus_fourth(res[3]),
    .result_bus_fifth(res[4]), .result_bus_sixth(res[5]),
    .result_bus_seventh(res[6]), .result_bus_last(res[7]),
    .overflow_first(overflow_first), .overflow_second(overflow_second));
  dma_ovf_latch u_ovf (.core_clk(core_clk), .clear(rst),
    .flag(overflow_first), .sticky(ovf_sticky));
  // 25 MHz clock
  always #20 core_clk = ~core_clk;
  // inputs always move 1 ns after the rising edge
  task tick(input integer n);
    begin
      repeat (n) @(posedge core_clk);
      #1;
    end
  endtask
  // config is static, so every change is made under reset
  task cfg(input [1:0] m, input [1:0] w, input ex, input sh);
    begin
      rst = 1'b1;
      mode_select = m;
      width_select = w;
      extra_output_stage = ex;
      mult_ctrl_stages = ex;
      adder_ctrl_stages = {1'b0, ex};
      product_reg_enable = ~ex;
      shift_data_enable = sh;
      shift_coef_enable = sh;
      tick(3);
      rst = 1'b0;
    end
  endtask
  // full precision product of n-bit operands under the current signs
  function [71:0] mul(input [35:0] a, input [35:0] b, input integer n);
    reg [71:0] x;
    reg [71:0] y;
    begin
      x = (sign_a && a[n-1]) ? ((~72'h0 << n) | a) : a;
      y = (sign_b && b[n-1]) ? ((~72'h0 << n) | b) : b;
      mul = x * y;
    end
  endfunction
  task check(input [71:0] seen, input [71:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  // about 160 cycles expected; far beyond that is a hang
  initial begin
    #(4000 * 40);
    mismatches = mismatches + 1;
    results;
  end
  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    {mode_select, width_select, mult_ctrl_stages, adder_ctrl_stages} = 7'h0;
    {extra_output_stage, shift_data_enable, shift_coef_enable} = 3'h0;
    {sign_a, sign_b, add_upper, add_lower, load_first, load_second} = 6'h0;
    {shift_data_in, shift_coef_in, group_clear} = 40'h0;
    product_reg_enable = 1'b1;
    group_enable = 4'hf;
    mismatches = 0;
    check_count = 0;
    for (j = 0; j < 4; j = j + 1) begin
      op_a[j] = 18'h3fe10 + j;
      op_b[j] = 18'h1f00d - 3 * j;
    end
    // simple 18x18 over every sign pairing, then hold and clear
    for (i = 0; i < 4; i = i + 1) begin
      cfg(`DMA_MODE_SIMPLE, `DMA_WIDTH_18, i[0], 1'b0);
      sign_a = i[1];
      sign_b = i[0];
      tick(6);
      for (j = 0; j < 4; j = j + 1) begin
        e = mul(op_a[j], op_b[j], 18);
        check({res[2*j+1], res[2*j]}, e[35:0]);
      end
      group_enable = 4'h0;
      tick(2);
      group_enable = 4'hf;
      group_clear = 4'h4;
      tick(1);
      check(res[0], 18'h0);
      group_clear = 4'h0;
    end
    $display("simple 18 test done");
    // eight 9x9 products, signed
    cfg(`DMA_MODE_SIMPLE, `DMA_WIDTH_9, 1'b0, 1'b0);
    tick(6);
    for (j = 0; j < 4; j = j + 1) begin
      e = mul(op_a[j][8:0], op_b[j][8:0], 9);
      check(res[2*j], e[17:0]);
      e = mul(op_a[j][17:9], op_b[j][17:9], 9);
      check(res[2*j+1], e[17:0]);
    end
    $display("simple 9 test done");
    // wide product with chains requested: parallel load must win
    cfg(`DMA_MODE_SIMPLE, `DMA_WIDTH_36, 1'b0, 1'b1);
    tick(7);
    e = mul({op_a[0], op_a[1]}, {op_b[0], op_b[1]}, 36);
    check({res[3], res[2], res[1], res[0]}, e);
    $display("wide test done");
    // complex multiply: real part subtracts, imaginary part adds
    cfg(`DMA_MODE_TWO_SUM, `DMA_WIDTH_18, 1'b1, 1'b0);
    add_upper = 1'b0;
    add_lower = 1'b1;
    tick(7);
    e = mul(op_a[0], op_b[0], 18) - mul(op_a[1], op_b[1], 18);
    check(acc0, e[53:0]);
    e = mul(op_a[2], op_b[2], 18) + mul(op_a[3], op_b[3], 18);
    check(acc1, e[53:0]);
    check(res[7], 18'h0);
    $display("two sum test done");
    // all four products kept at 18 bits, as user logic must
    cfg(`DMA_MODE_FOUR_SUM, `DMA_WIDTH_18, 1'b0, 1'b0);
    tick(7);
    e = mul(op_a[0], op_b[0], 18) - mul(op_a[1], op_b[1], 18)
      + mul(op_a[2], op_b[2], 18) + mul(op_a[3], op_b[3], 18);
    check(acc0, e[53:0]);
    $display("four sum test done");
    // nine-bit pairs: first difference, then the four-term total
    cfg(`DMA_MODE_TWO_SUM, `DMA_WIDTH_9, 1'b0, 1'b0);
    tick(6);
    e = mul(op_a[0][8:0], op_b[0][8:0], 9)
      - mul(op_a[1][8:0], op_b[1][8:0], 9);
    check({res[1], res[0]}, e[35:0]);
    cfg(`DMA_MODE_FOUR_SUM, `DMA_WIDTH_9, 1'b0, 1'b0);
    tick(6);
    e = e + mul(op_a[2][8:0], op_b[2][8:0], 9)
      + mul(op_a[3][8:0], op_b[3][8:0], 9);
    check({res[1], res[0]}, e[35:0]);
    $display("nine-bit sum test done");
    // accumulate: load, add, subtract until the total goes below zero
    cfg(`DMA_MODE_MAC, `DMA_WIDTH_18, 1'b0, 1'b0);
    {sign_a, sign_b, add_upper, add_lower} = 4'h3;
    {load_first, load_second} = 2'h3;
    {op_a[1], op_b[1], op_a[3], op_b[3]} = {4{18'h00100}};
    tick(6);
    check(acc0, 54'h10000);
    check(acc1, 54'h10000);
    {load_first, load_second} = 2'h0;
    tick(4);
    prev = acc0;
    tick(1);
    check(acc0 - prev, 54'h10000);
    check(ovf_sticky, 1'b0);
    {add_upper, add_lower} = 2'h0;
    tick(4);
    prev = acc0;
    tick(1);
    check(prev - acc0, 54'h10000);
    tick(20);
    check(ovf_sticky, 1'b1);
    $display("accumulate test done");
    // fir operands step through both chains toward the next tile
    cfg(`DMA_MODE_FOUR_SUM, `DMA_WIDTH_18, 1'b0, 1'b1);
    for (j = 0; j < 12; j = j + 1) begin
      if (j > 3) begin
        check(shift_data_out, j - 4);
        check(shift_coef_out, j + 12);
      end
      shift_data_in = j;
      shift_coef_in = j + 16;
      tick(1);
    end
    $display("chain test done");
    results;
  end
endmodule
